// *** tmr_core.sv ***
// What this block does
// - writing one to the prescaler reset bit clears the shared prescaler
// - the reset bit clears itself and always reads back as zero
// - writing zero to the reset bit changes nothing
// - one prescaler reset restarts the period for both sharing timers
// - with no clock source selected the counter neither counts nor clears
// - both active compare values checked on each counter tick; a match sets its flag
// - a pin or comparator edge copies the counter into the capture register, except in modes with capture as top
// - an optional filter drops short spikes before capture
// - top is 0x00ff, 0x01ff, 0x03ff, 0xffff, compare a or capture, per mode
// - compare a as top drives no output and stays double buffered, except in mode 4 where it reloads at once
// - bottom flagged at 0x0000, maximum at 0xffff
// - counter, compares and capture are 16 bits, reached bytewise
// - one 8-bit high-byte holding register serves all 16-bit writes and the counter and capture reads
// - low-byte write loads holding byte and written byte together, capture only in modes with capture as top
// - counter and capture low-byte reads copy the high byte into the holding register
// - compare high-byte reads bypass the holding register
// - four event flags in one flag register, each with its own mask
// - both control registers are plain 8-bit read and write
// - a counter write beats any count or clear in that cycle
// - clock select zero stops counting, counter stays accessible
`timescale 1ns/100ps
module tmr_core #(
	parameter int PW = tmr_pkg::PRESC_W
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic clk_en,
	input wire tmr_pkg::tmr_io_s io_req,
	output logic [7:0] io_rdata,
	input wire logic ext_clk_pin,
	input wire logic capture_input_pin,
	input wire logic acmp_out,
	input wire tmr_pkg::tmr_irq_s irq_ack,
	output tmr_pkg::tmr_irq_s irq_req,
	output logic shared_prescaler_reset,
	output logic at_bottom,
	output logic at_max,
	output logic at_top
);

	// ----------------------------------------
	// mode decoding
	// ----------------------------------------
	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] oa,
		input logic [15:0] ic);
		case (m)
			4'h1, 4'h5: top_of = tmr_pkg::TOP8;
			4'h2, 4'h6: top_of = tmr_pkg::TOP9;
			4'h3, 4'h7: top_of = tmr_pkg::TOP10;
			4'h4, 4'h9, 4'hb, 4'hf: top_of = oa;
			4'h8, 4'ha, 4'hc, 4'he: top_of = ic;
			default: top_of = tmr_pkg::MAX;
		endcase
	endfunction

	function automatic logic is_pc(input logic [3:0] m);
		is_pc = (m inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
	endfunction

	function automatic logic icr_top(input logic [3:0] m);
		icr_top = (m inside {4'h8, 4'ha, 4'hc, 4'he});
	endfunction

	// ----------------------------------------
	// pin synchronisers and capture filter
	// ----------------------------------------
	logic [2:0] s1, s2, s3, lvl, next_lvl;
	logic [tmr_pkg::NC_LEN-1:0] nc, next_nc;
	logic cap_f, next_cap_f, cap_prev, t1_prev;
	logic src;
	logic [7:0] ctrl_a, ctrl_b;

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			next_lvl[i] = (s2[i] == s3[i]) ? s3[i] : lvl[i];
		end
		src = ctrl_a[tmr_pkg::B_ACIC] ? lvl[2] : lvl[1];
		next_nc = {nc[tmr_pkg::NC_LEN-2:0], src};
		next_cap_f = cap_f;
		if (!ctrl_b[tmr_pkg::B_ICNC]) begin
			next_cap_f = src;
		end else if (&nc) begin
			next_cap_f = 1'b1;
		end else if (~|nc) begin
			next_cap_f = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s1 <= 3'h0;
			s2 <= 3'h0;
			s3 <= 3'h0;
			lvl <= 3'h0;
			nc <= '0;
			cap_f <= 1'b0;
			cap_prev <= 1'b0;
			t1_prev <= 1'b0;
		end else if (clk_en) begin
			s1 <= {acmp_out, capture_input_pin, ext_clk_pin};
			s2 <= s1;
			s3 <= s2;
			lvl <= next_lvl;
			nc <= next_nc;
			cap_f <= next_cap_f;
			cap_prev <= cap_f;
			t1_prev <= lvl[0];
		end
	end

	// ----------------------------------------
	// timer state and register file
	// ----------------------------------------
	logic [PW-1:0] presc, next_presc;
	logic [15:0] cnt, next_cnt, oca, next_oca, ocb, next_ocb;
	logic [15:0] oca_buf, next_oca_buf, ocb_buf, next_ocb_buf, icr, next_icr;
	logic [7:0] temp, next_temp, next_ctrl_a, next_ctrl_b, flags, next_flags;
	logic [7:0] mask, next_mask, next_rdata;
	logic dir_up, next_dir_up, next_psr;
	logic [3:0] mode;
	logic [2:0] cs;
	logic tick, wr, rd, psr_hit, cap_ev, cap_hit, cnt_wr, at_top_i;
	logic [15:0] top;
	logic [7:0] set_f, clr_f, ack_f;

	assign mode = {ctrl_b[4:3], ctrl_a[1:0]};
	assign cs = ctrl_b[2:0];
	assign top = top_of(mode, oca, icr);
	assign at_top_i = (cnt == top);
	assign wr = io_req.wr;
	assign rd = io_req.rd;
	assign psr_hit = wr && io_req.addr == tmr_pkg::A_PSR && io_req.wdata[tmr_pkg::B_PSR];
	assign cnt_wr = wr && io_req.addr == tmr_pkg::A_CNT_L;
	assign cap_ev = ctrl_b[tmr_pkg::B_ICES] ? (cap_f & ~cap_prev) : (~cap_f & cap_prev);
	assign cap_hit = cap_ev && !icr_top(mode);

	always_comb begin
		case (cs)
			tmr_pkg::CS_STOP: tick = 1'b0;
			tmr_pkg::CS_DIV1: tick = 1'b1;
			tmr_pkg::CS_DIV8: tick = &presc[2:0];
			tmr_pkg::CS_DIV64: tick = &presc[5:0];
			tmr_pkg::CS_DIV256: tick = &presc[7:0];
			tmr_pkg::CS_DIV1024: tick = &presc[9:0];
			tmr_pkg::CS_EXT_FALL: tick = ~lvl[0] & t1_prev;
			default: tick = lvl[0] & ~t1_prev;
		endcase
		next_presc = psr_hit ? '0 : presc + PW'(1);
		next_psr = psr_hit;
		next_cnt = cnt;
		next_dir_up = dir_up;
		set_f = 8'h00;
		if (tick) begin
			if (is_pc(mode)) begin
				if (dir_up) begin
					next_dir_up = !at_top_i;
					next_cnt = at_top_i ? cnt - 16'h0001 : cnt + 16'h0001;
				end else begin
					next_dir_up = (cnt == tmr_pkg::BOTTOM);
					next_cnt = next_dir_up ? cnt + 16'h0001 : cnt - 16'h0001;
					set_f[tmr_pkg::B_TOV] = next_dir_up;
				end
			end else begin
				next_cnt = at_top_i ? tmr_pkg::BOTTOM : cnt + 16'h0001;
				set_f[tmr_pkg::B_TOV] = at_top_i;
			end
			set_f[tmr_pkg::B_OCFA] = (cnt == oca);
			set_f[tmr_pkg::B_OCFB] = (cnt == ocb);
		end
		set_f[tmr_pkg::B_ICF] = cap_hit;
		next_temp = temp;
		next_oca_buf = oca_buf;
		next_ocb_buf = ocb_buf;
		next_icr = cap_hit ? cnt : icr;
		next_ctrl_a = ctrl_a;
		next_ctrl_b = ctrl_b;
		next_mask = mask;
		clr_f = 8'h00;
		if (wr) begin
			case (io_req.addr)
				tmr_pkg::A_CNT_H, tmr_pkg::A_OCA_H, tmr_pkg::A_OCB_H, tmr_pkg::A_ICR_H: begin
					next_temp = io_req.wdata;
				end
				tmr_pkg::A_CNT_L: begin
					next_cnt = {temp, io_req.wdata};
					next_dir_up = 1'b1;
				end
				tmr_pkg::A_OCA_L: next_oca_buf = {temp, io_req.wdata};
				tmr_pkg::A_OCB_L: next_ocb_buf = {temp, io_req.wdata};
				tmr_pkg::A_ICR_L: begin
					if (icr_top(mode)) begin
						next_icr = {temp, io_req.wdata};
					end
				end
				tmr_pkg::A_CTRL_A: next_ctrl_a = io_req.wdata;
				tmr_pkg::A_CTRL_B: next_ctrl_b = io_req.wdata;
				tmr_pkg::A_FLAG: clr_f = io_req.wdata;
				tmr_pkg::A_MASK: next_mask = io_req.wdata;
				default: ;
			endcase
		end
		// pwm modes reload the compare values at top, others at once
		next_oca = oca;
		next_ocb = ocb;
		if (!(mode inside {4'h0, 4'h4, 4'hc, 4'hd}) ? (tick && at_top_i) : 1'b1) begin
			next_oca = next_oca_buf;
			next_ocb = next_ocb_buf;
		end
		ack_f = 8'h00;
		ack_f[tmr_pkg::B_TOV] = irq_ack.ovf;
		ack_f[tmr_pkg::B_OCFA] = irq_ack.cmpa;
		ack_f[tmr_pkg::B_OCFB] = irq_ack.cmpb;
		ack_f[tmr_pkg::B_ICF] = irq_ack.capt;
		next_flags = ((flags & ~(clr_f | ack_f)) | set_f) & 8'h3c;
		next_rdata = io_rdata;
		if (rd) begin
			case (io_req.addr)
				tmr_pkg::A_CNT_L: begin
					next_rdata = cnt[7:0];
					next_temp = cnt[15:8];
				end
				tmr_pkg::A_ICR_L: begin
					next_rdata = icr[7:0];
					next_temp = icr[15:8];
				end
				tmr_pkg::A_CNT_H, tmr_pkg::A_ICR_H: next_rdata = temp;
				tmr_pkg::A_OCA_L: next_rdata = oca_buf[7:0];
				tmr_pkg::A_OCA_H: next_rdata = oca_buf[15:8];
				tmr_pkg::A_OCB_L: next_rdata = ocb_buf[7:0];
				tmr_pkg::A_OCB_H: next_rdata = ocb_buf[15:8];
				tmr_pkg::A_CTRL_A: next_rdata = ctrl_a;
				tmr_pkg::A_CTRL_B: next_rdata = ctrl_b;
				tmr_pkg::A_FLAG: next_rdata = flags;
				tmr_pkg::A_MASK: next_rdata = mask;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			presc <= '0;
			cnt <= tmr_pkg::RST16;
			oca <= tmr_pkg::RST16;
			ocb <= tmr_pkg::RST16;
			oca_buf <= tmr_pkg::RST16;
			ocb_buf <= tmr_pkg::RST16;
			icr <= tmr_pkg::RST16;
			temp <= tmr_pkg::RST8;
			ctrl_a <= tmr_pkg::RST8;
			ctrl_b <= tmr_pkg::RST8;
			flags <= tmr_pkg::RST8;
			mask <= tmr_pkg::RST8;
			io_rdata <= tmr_pkg::RST8;
			dir_up <= 1'b1;
			shared_prescaler_reset <= 1'b0;
		end else if (clk_en) begin
			presc <= next_presc;
			cnt <= next_cnt;
			oca <= next_oca;
			ocb <= next_ocb;
			oca_buf <= next_oca_buf;
			ocb_buf <= next_ocb_buf;
			icr <= next_icr;
			temp <= next_temp;
			ctrl_a <= next_ctrl_a;
			ctrl_b <= next_ctrl_b;
			flags <= next_flags;
			mask <= next_mask;
			io_rdata <= next_rdata;
			dir_up <= next_dir_up;
			shared_prescaler_reset <= next_psr;
		end
	end

	assign at_bottom = (cnt == tmr_pkg::BOTTOM);
	assign at_max = (cnt == tmr_pkg::MAX);
	assign at_top = at_top_i;
	assign irq_req.ovf = flags[tmr_pkg::B_TOV] & mask[tmr_pkg::B_TOV];
	assign irq_req.cmpa = flags[tmr_pkg::B_OCFA] & mask[tmr_pkg::B_OCFA];
	assign irq_req.cmpb = flags[tmr_pkg::B_OCFB] & mask[tmr_pkg::B_OCFB];
	assign irq_req.capt = flags[tmr_pkg::B_ICF] & mask[tmr_pkg::B_ICF];

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence s_hi_wr;
		clk_en && wr && io_req.addr == tmr_pkg::A_CNT_H;
	endsequence
	sequence s_lo_wr;
		clk_en && wr && io_req.addr == tmr_pkg::A_CNT_L;
	endsequence

	AST_PSR_CLEAR: assert property (clk_en && psr_hit
		|=> presc == '0 && shared_prescaler_reset) else $error("prescaler not restarted");
	AST_PSR_READ0: assert property (clk_en && rd && io_req.addr == tmr_pkg::A_PSR
		|=> io_rdata == 8'h00) else $error("prescaler reset bit read nonzero");
	AST_STOPPED: assert property (clk_en && cs == tmr_pkg::CS_STOP && !cnt_wr
		|=> $stable(cnt)) else $error("counter moved with no clock source");
	AST_CMP_A: assert property (clk_en && tick && cnt == oca |=> flags[tmr_pkg::B_OCFA])
		else $error("compare a match not flagged");
	AST_CAPTURE: assert property (clk_en && cap_hit
		|=> icr == $past(cnt) && flags[tmr_pkg::B_ICF])
		else $error("capture did not store counter");
	AST_WR16: assert property (s_hi_wr ##1 s_lo_wr
		|=> cnt == {$past(io_req.wdata, 2), $past(io_req.wdata)})
		else $error("16-bit counter write wrong");
	AST_RD_LOW: assert property (clk_en && rd && io_req.addr == tmr_pkg::A_CNT_L
		|=> temp == $past(cnt[15:8])) else $error("holding byte not loaded on low read");
	AST_OCR_RD: assert property (clk_en && rd && !wr && io_req.addr == tmr_pkg::A_OCA_H
		|=> $stable(temp) && io_rdata == $past(oca_buf[15:8]))
		else $error("compare high read used holding byte");
	AST_FLAG_HOLD: assert property (flags[tmr_pkg::B_OCFA]
		&& !(clk_en && (irq_ack.cmpa || wr && io_req.addr == tmr_pkg::A_FLAG))
		|=> flags[tmr_pkg::B_OCFA]) else $error("compare flag lost");

endmodule // tmr_core

// *** tmr_pkg.sv ***
package tmr_pkg;

	// ----------------------------------------
	// register addresses on the 8-bit io bus
	// ----------------------------------------
	localparam int AW = 6;
	localparam logic [AW-1:0] A_CTRL_A = 6'h00;
	localparam logic [AW-1:0] A_CTRL_B = 6'h01;
	localparam logic [AW-1:0] A_CNT_L = 6'h02;
	localparam logic [AW-1:0] A_CNT_H = 6'h03;
	localparam logic [AW-1:0] A_OCA_L = 6'h04;
	localparam logic [AW-1:0] A_OCA_H = 6'h05;
	localparam logic [AW-1:0] A_OCB_L = 6'h06;
	localparam logic [AW-1:0] A_OCB_H = 6'h07;
	localparam logic [AW-1:0] A_ICR_L = 6'h08;
	localparam logic [AW-1:0] A_ICR_H = 6'h09;
	localparam logic [AW-1:0] A_FLAG = 6'h0a;
	localparam logic [AW-1:0] A_MASK = 6'h0b;
	localparam logic [AW-1:0] A_PSR = 6'h0c;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int B_PSR = 0;
	localparam int B_TOV = 2;
	localparam int B_OCFB = 3;
	localparam int B_OCFA = 4;
	localparam int B_ICF = 5;
	localparam int B_ACIC = 3;
	localparam int B_ICES = 6;
	localparam int B_ICNC = 7;

	// ----------------------------------------
	// values
	// ----------------------------------------
	localparam logic [7:0] RST8 = 8'h00;
	localparam logic [15:0] RST16 = 16'h0000;
	localparam logic [15:0] BOTTOM = 16'h0000;
	localparam logic [15:0] MAX = 16'hffff;
	localparam logic [15:0] TOP8 = 16'h00ff;
	localparam logic [15:0] TOP9 = 16'h01ff;
	localparam logic [15:0] TOP10 = 16'h03ff;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam int PRESC_W = 10;
	localparam int NC_LEN = 4;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} tmr_io_s;

	typedef struct packed {
		logic capt;
		logic cmpa;
		logic cmpb;
		logic ovf;
	} tmr_irq_s;

endpackage

// *** tmr_cpu_model.sv ***
`timescale 1ns/100ps
module tmr_cpu_model (
	input wire logic clk_sys,
	input wire logic [7:0] io_rdata,
	output tmr_pkg::tmr_io_s io_req
);
	initial io_req = '0;

	// ----------------------------------------
	// byte cycles, strobe held one edge
	// ----------------------------------------
	// released address and data lines show the inverse of the last value
	// single master, no interrupt code shares the holding byte
	task automatic wr8(input logic [tmr_pkg::AW-1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
		@(posedge clk_sys);
		io_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
	endtask

	task automatic rd8(input logic [tmr_pkg::AW-1:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: ~io_req.wdata};
		@(posedge clk_sys);
		io_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~io_req.wdata};
		#1 d = io_rdata;
	endtask

	// high byte first on write
	// both bytes back to back, strobe held across the pair
	task automatic wr16(input logic [tmr_pkg::AW-1:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		io_req <= '{addr: a + 6'h01, wr: 1'b1, rd: 1'b0, wdata: d[15:8]};
		@(posedge clk_sys);
		io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d[7:0]};
		@(posedge clk_sys);
		io_req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d[7:0]};
	endtask

	// low byte first on read
	task automatic rd16(input logic [tmr_pkg::AW-1:0] a, output logic [15:0] d);
		logic [7:0] l;
		logic [7:0] h;
		rd8(a, l);
		rd8(a + 6'h01, h);
		d = {h, l};
	endtask
endmodule // tmr_cpu_model

// *** timer16_byte_access_core_tb.sv ***
`timescale 1ns/100ps
module timer16_byte_access_core_tb;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic clk_en = 1'b1;
	logic ext_clk_pin = 1'b0;
	logic capture_input_pin = 1'b0;
	logic acmp_out = 1'b0;
	tmr_pkg::tmr_irq_s irq_ack = '0;
	tmr_pkg::tmr_irq_s irq_req;
	tmr_pkg::tmr_io_s io_req;
	logic [7:0] io_rdata;
	logic shared_prescaler_reset;
	logic at_bottom;
	logic at_max;
	logic at_top;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;
	logic [31:0] seed = 32'd59;
	logic [15:0] m[4];
	logic [15:0] tops[6];
	logic [7:0] b;
	logic [15:0] v;
	logic [7:0] mode_a[6] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h00, 8'h00};
	logic [7:0] mode_b[6] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h18, 8'h00};

	tmr_core i_dut (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .io_req(io_req),
		.io_rdata(io_rdata), .ext_clk_pin(ext_clk_pin), .capture_input_pin(capture_input_pin),
		.acmp_out(acmp_out), .irq_ack(irq_ack), .irq_req(irq_req),
		.shared_prescaler_reset(shared_prescaler_reset), .at_bottom(at_bottom),
		.at_max(at_max), .at_top(at_top));
	tmr_cpu_model i_cpu (.clk_sys(clk_sys), .io_rdata(io_rdata), .io_req(io_req));

	always #5 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			results();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [15:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction

	task automatic results();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
		logic [7:0] d;
		i_cpu.rd8(a, d);
		chk({8'h00, d}, exp);
	endtask

	task automatic rdc16(input logic [5:0] a, input logic [15:0] exp);
		logic [15:0] d;
		i_cpu.rd16(a, d);
		chk(d, exp);
	endtask

	task automatic w16(input logic [5:0] a, input int i, input logic [15:0] d);
		i_cpu.wr16(a, d);
		m[i] = d;
	endtask

	task automatic wirq(input logic [3:0] k);
		#1;
		for (int i = 0; i < 80 && (irq_req & k) == 4'h0; i++) begin
			@(posedge clk_sys);
			#1;
		end
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		#1 chk(at_bottom, 1'b1);
		rdc(tmr_pkg::A_CTRL_A, 16'h0);
		rdc(tmr_pkg::A_FLAG, 16'h0);
		rdc16(tmr_pkg::A_CNT_L, 16'h0);
		v = xs();
		i_cpu.wr8(tmr_pkg::A_CTRL_A, v[7:0]);
		i_cpu.wr8(tmr_pkg::A_CTRL_B, v[15:8] & 8'hf8);
		rdc(tmr_pkg::A_CTRL_A, {8'h00, v[7:0]});
		rdc(tmr_pkg::A_CTRL_B, {8'h00, v[15:8] & 8'hf8});
		i_cpu.wr8(tmr_pkg::A_CTRL_A, 8'h00);
		i_cpu.wr8(tmr_pkg::A_CTRL_B, 8'h00);
		w16(tmr_pkg::A_CNT_L, 0, xs());
		w16(tmr_pkg::A_OCA_L, 1, xs());
		rdc16(tmr_pkg::A_OCA_L, m[1]);
		i_cpu.rd8(tmr_pkg::A_CNT_L, b);
		rdc(tmr_pkg::A_OCA_H, m[1] >> 8);
		rdc(tmr_pkg::A_CNT_H, m[0] >> 8);
		i_cpu.wr8(tmr_pkg::A_CNT_H, 8'h5a);
		i_cpu.wr8(tmr_pkg::A_OCB_L, 8'h3c);
		rdc16(tmr_pkg::A_OCB_L, 16'h5a3c);
		rdc16(tmr_pkg::A_CNT_L, m[0]);
		tops = '{tmr_pkg::TOP8, tmr_pkg::TOP9, tmr_pkg::TOP10, m[1], 16'h1234, tmr_pkg::MAX};
		for (int i = 0; i < 6; i++) begin
			i_cpu.wr8(tmr_pkg::A_CTRL_A, mode_a[i]);
			i_cpu.wr8(tmr_pkg::A_CTRL_B, mode_b[i]);
			if (i == 4) begin
				w16(tmr_pkg::A_ICR_L, 3, tops[4]);
				rdc16(tmr_pkg::A_ICR_L, m[3]);
			end
			i_cpu.wr16(tmr_pkg::A_CNT_L, tops[i]);
			#1 chk(at_top, 1'b1);
			chk(at_max, tops[i] == tmr_pkg::MAX);
			i_cpu.wr16(tmr_pkg::A_CNT_L, tops[i] - 16'h0001);
			#1 chk(at_top, 1'b0);
		end
		i_cpu.wr8(tmr_pkg::A_CTRL_A, 8'h00);
		i_cpu.wr8(tmr_pkg::A_CTRL_B, 8'h00);
		w16(tmr_pkg::A_OCA_L, 1, 16'h0010);
		w16(tmr_pkg::A_OCB_L, 2, 16'h0020);
		w16(tmr_pkg::A_CNT_L, 0, 16'hfffc);
		i_cpu.wr8(tmr_pkg::A_MASK, 8'h3c);
		i_cpu.wr8(tmr_pkg::A_FLAG, 8'hff);
		i_cpu.wr8(tmr_pkg::A_CTRL_B, {5'h00, tmr_pkg::CS_DIV1});
		wirq(4'b0001);
		chk(irq_req, 4'b0001);
		chk(at_bottom, 1'b1);
		@(posedge clk_sys);
		irq_ack <= 4'b0001;
		@(posedge clk_sys);
		irq_ack <= 4'b0000;
		#1 chk(irq_req, 4'b0000);
		wirq(4'b0100);
		chk(irq_req, 4'b0100);
		wirq(4'b0010);
		chk(irq_req, 4'b0110);
		i_cpu.wr8(tmr_pkg::A_CTRL_B, 8'h00);
		rdc(tmr_pkg::A_FLAG, 16'h0018);
		i_cpu.wr8(tmr_pkg::A_MASK, 8'h08);
		#1 chk(irq_req, 4'b0010);
		i_cpu.wr8(tmr_pkg::A_FLAG, 8'h10);
		rdc(tmr_pkg::A_FLAG, 16'h0008);
		i_cpu.wr8(tmr_pkg::A_CTRL_B, {5'h00, tmr_pkg::CS_DIV1});
		i_cpu.wr16(tmr_pkg::A_CNT_L, tmr_pkg::MAX);
		#1 chk(at_max, 1'b1);
		@(posedge clk_sys);
		#1 chk(at_bottom, 1'b1);
		i_cpu.wr8(tmr_pkg::A_CTRL_B, 8'h00);
		i_cpu.wr8(tmr_pkg::A_PSR, 8'h01);
		#1 chk(shared_prescaler_reset, 1'b1);
		@(posedge clk_sys);
		#1 chk(shared_prescaler_reset, 1'b0);
		rdc(tmr_pkg::A_PSR, 16'h0);
		i_cpu.wr8(tmr_pkg::A_PSR, 8'hfe);
		#1 chk(shared_prescaler_reset, 1'b0);
		i_cpu.wr8(tmr_pkg::A_MASK, 8'h20);
		w16(tmr_pkg::A_CNT_L, 0, xs());
		i_cpu.wr8(tmr_pkg::A_CTRL_B, 8'h40);
		i_cpu.wr8(tmr_pkg::A_FLAG, 8'hff);
		capture_input_pin <= 1'b1;
		wirq(4'b1000);
		chk(irq_req, 4'b1000);
		rdc16(tmr_pkg::A_ICR_L, m[0]);
		i_cpu.wr8(tmr_pkg::A_CTRL_A, 8'h08);
		w16(tmr_pkg::A_CNT_L, 0, xs());
		i_cpu.wr8(tmr_pkg::A_FLAG, 8'hff);
		acmp_out <= 1'b1;
		wirq(4'b1000);
		chk(irq_req, 4'b1000);
		rdc16(tmr_pkg::A_ICR_L, m[0]);
		i_cpu.wr16(tmr_pkg::A_ICR_L, ~m[0]);
		rdc16(tmr_pkg::A_ICR_L, m[0]);
		i_cpu.wr8(tmr_pkg::A_CTRL_A, 8'h00);
		i_cpu.wr8(tmr_pkg::A_CTRL_B, 8'hc0);
		capture_input_pin <= 1'b0;
		repeat (10) @(posedge clk_sys);
		i_cpu.wr8(tmr_pkg::A_FLAG, 8'hff);
		capture_input_pin <= 1'b1;
		repeat (2) @(posedge clk_sys);
		capture_input_pin <= 1'b0;
		repeat (12) @(posedge clk_sys);
		#1 chk(irq_req, 4'b0000);
		@(posedge clk_sys);
		capture_input_pin <= 1'b1;
		wirq(4'b1000);
		chk(irq_req, 4'b1000);
		// ----------------------------------------
		// clock enable freeze
		// ----------------------------------------
		i_cpu.wr8(tmr_pkg::A_CTRL_B, {5'h00, tmr_pkg::CS_DIV1});
		i_cpu.wr16(tmr_pkg::A_CNT_L, tmr_pkg::MAX);
		clk_en <= 1'b0;
		repeat (3) @(posedge clk_sys);
		#1 chk(at_max, 1'b1);
		@(posedge clk_sys);
		clk_en <= 1'b1;
		@(posedge clk_sys);
		#1 chk(at_bottom, 1'b1);
		// ----------------------------------------
		// prescaler restart with the /8 tap
		// ----------------------------------------
		i_cpu.wr8(tmr_pkg::A_CTRL_B, {5'h00, tmr_pkg::CS_DIV8});
		i_cpu.wr8(tmr_pkg::A_PSR, 8'h01);
		i_cpu.wr16(tmr_pkg::A_CNT_L, 16'h0000);
		repeat (4) @(posedge clk_sys);
		#1 chk(at_bottom, 1'b1);
		@(posedge clk_sys);
		#1 chk(at_bottom, 1'b0);
		i_cpu.wr8(tmr_pkg::A_CTRL_B, 8'h00);
		rdc16(tmr_pkg::A_CNT_L, 16'h0001);
		// ----------------------------------------
		// external rising clock, up/down turn at top
		// ----------------------------------------
		i_cpu.wr8(tmr_pkg::A_CTRL_A, 8'h01);
		i_cpu.wr8(tmr_pkg::A_CTRL_B, 8'h07);
		i_cpu.wr16(tmr_pkg::A_CNT_L, tmr_pkg::TOP8);
		for (int i = 0; i < 4; i++) begin
			ext_clk_pin <= ~ext_clk_pin;
			repeat (6) @(posedge clk_sys);
		end
		i_cpu.wr8(tmr_pkg::A_CTRL_B, 8'h00);
		rdc16(tmr_pkg::A_CNT_L, 16'h00fd);
		results();
	end
endmodule // timer16_byte_access_core_tb
